// ### logic/slc_link_regs.sv
`timescale 1ns/1ns
// Behaviour
// - Link enable bit 0, resets to 1; 0 disables, 1 enables the link.
// - Link disabled holds link logic in reset and powers serializers down.
// - Link disabled gates the link clocks off.
// - Link disabled holds multiframe counter reset; SYSREF cannot realign it.
// - Eight-bit link mode field, resets to 0x02, picks link configuration.
// - Mode writes not permitted by the mode lock are refused.
// - Frames field holds K-1 in eight bits, resets to 0x1F.
// - In 64b/66b modes K comes from the mode as 256*E/F.
// - Manual sync bit 0 resets to 1; writing 0 requests resync.
// - Manual sync bit at 0 always raises a sync request.
// - A stuck-low selected pin keeps requesting unless no-pin source chosen.
// - Control resets to 0x03: lanes bit 4, source 3:2, format 1, scrambler 0.
// - Source 0 single-ended pin, 1 timestamp pin, 2 no pin.
// - Format bit 0 offset binary, 1 two's complement; resets to 1.
// - Scrambler bit acts only in 8b/10b; 64b/66b always scrambles.
module slc_link_regs (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire slc_pkg::slc_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire slc_pkg::slc_data_t reg_wdata,
    output slc_pkg::slc_data_t reg_rdata,
    input wire logic [255:0] mode_permit,
    input wire logic mode_is_64b66b,
    input wire logic [7:0] mode_e,
    input wire logic [7:0] mode_f,
    input wire logic frame_tick,
    input wire logic single_ended_sync_pin_n,
    input wire logic timestamp_pin_n,
    input wire logic sysref_pin,
    output logic link_enable,
    output logic link_rst_b,
    output logic serializer_pd,
    output logic link_clk_en,
    output logic [7:0] link_mode_select,
    output logic [7:0] frames_per_multiframe_m1,
    output logic [15:0] effective_k_m1,
    output logic [15:0] multiframe_clock_counter,
    output logic sync_request,
    output logic manual_sync_request_n,
    output slc_pkg::slc_sync_sel_t sync_source_sel,
    output logic sample_format,
    output logic scrambler_enable,
    output logic scrambler_active,
    output logic upper_lane_mapping
);
    import slc_pkg::*;

    localparam logic [7:0] ctrl_reset_value = `SLC_RST_CTRL;

    logic wr_en;
    logic wr_mode;
    logic wr_km1;
    logic wr_sync;
    logic wr_ctrl;
    logic sysref_sync;
    logic sysref_prev;
    logic sysref_rise;

    // K-1 for a 64b/66b mode, guarding against an empty F field
    function automatic logic [15:0] k_m1_from_mode(input logic [7:0] e, input logic [7:0] f);
        logic [15:0] k;
        k = 16'h0000;
        if (f != 8'h00) begin
            k = ({8'h00, e} * `SLC_K_SCALE) / {8'h00, f};
        end
        return (k == 16'h0000) ? 16'h0000 : k - 16'h0001;
    endfunction

    // Address decode of write strobes
    assign wr_en = reg_wr && reg_addr == `SLC_ADDR_LINK_EN;
    assign wr_mode = reg_wr && reg_addr == `SLC_ADDR_MODE && mode_permit[reg_wdata];
    assign wr_km1 = reg_wr && reg_addr == `SLC_ADDR_KM1;
    assign wr_sync = reg_wr && reg_addr == `SLC_ADDR_SYNC;
    assign wr_ctrl = reg_wr && reg_addr == `SLC_ADDR_CTRL;

    // Link enable
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            link_enable <= `SLC_RST_LINK_EN;
        end else if (wr_en) begin
            link_enable <= reg_wdata[0];
        end
    end

    // Link mode, refused when the lock does not permit it
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            link_mode_select <= `SLC_RST_MODE;
        end else if (wr_mode) begin
            link_mode_select <= reg_wdata;
        end
    end

    // Frames per multiframe minus one
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            frames_per_multiframe_m1 <= `SLC_RST_KM1;
        end else if (wr_km1) begin
            frames_per_multiframe_m1 <= reg_wdata;
        end
    end

    // Manual sync request, active low
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            manual_sync_request_n <= `SLC_RST_SYNC_N;
        end else if (wr_sync) begin
            manual_sync_request_n <= reg_wdata[0];
        end
    end

    // Control fields
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            upper_lane_mapping <= ctrl_reset_value[`SLC_CTRL_LANE_BIT];
            sync_source_sel <= slc_sync_sel_t'(
                ctrl_reset_value[`SLC_CTRL_SEL_MSB:`SLC_CTRL_SEL_LSB]);
            sample_format <= ctrl_reset_value[`SLC_CTRL_FMT_BIT];
            scrambler_enable <= ctrl_reset_value[`SLC_CTRL_SCR_BIT];
        end else if (wr_ctrl) begin
            upper_lane_mapping <= reg_wdata[`SLC_CTRL_LANE_BIT];
            sync_source_sel <= slc_sync_sel_t'(reg_wdata[`SLC_CTRL_SEL_MSB:`SLC_CTRL_SEL_LSB]);
            sample_format <= reg_wdata[`SLC_CTRL_FMT_BIT];
            scrambler_enable <= reg_wdata[`SLC_CTRL_SCR_BIT];
        end
    end

    // Registered read data; reserved bits and unmapped offsets read zero
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `SLC_ADDR_LINK_EN: reg_rdata <= {7'h00, link_enable};
                `SLC_ADDR_MODE: reg_rdata <= link_mode_select;
                `SLC_ADDR_KM1: reg_rdata <= frames_per_multiframe_m1;
                `SLC_ADDR_SYNC: reg_rdata <= {7'h00, manual_sync_request_n};
                `SLC_ADDR_CTRL: reg_rdata <= {3'h0, upper_lane_mapping, sync_source_sel,
                    sample_format, scrambler_enable};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // Disabled link: reset, clocks gated, serializers down
    assign link_rst_b = link_enable;
    assign serializer_pd = !link_enable;
    assign link_clk_en = link_enable;

    // 64b/66b ignores the frames field and always scrambles
    assign effective_k_m1 = mode_is_64b66b ? k_m1_from_mode(mode_e, mode_f)
        : {8'h00, frames_per_multiframe_m1};
    assign scrambler_active = mode_is_64b66b | scrambler_enable;

    slc_sync_req u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .single_ended_sync_pin_n(single_ended_sync_pin_n),
        .timestamp_pin_n(timestamp_pin_n),
        .sysref_pin(sysref_pin),
        .manual_sync_request_n(manual_sync_request_n),
        .sync_source_sel(sync_source_sel),
        .sync_request(sync_request),
        .sysref_sync(sysref_sync)
    );

    // SYSREF edge detect on the synchronised level
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sysref_prev <= 1'b0;
        end else begin
            sysref_prev <= sysref_sync;
        end
    end
    assign sysref_rise = sysref_sync && !sysref_prev;

    // Multiframe counter, held at zero while the link is disabled
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !link_enable) begin
            multiframe_clock_counter <= 16'h0000;
        end else if (sysref_rise) begin
            multiframe_clock_counter <= 16'h0000;
        end else if (frame_tick) begin
            multiframe_clock_counter <= (multiframe_clock_counter >= effective_k_m1) ? 16'h0000
                : multiframe_clock_counter + 16'h0001;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_reset_values: assert property (disable iff (1'b0)
        !rst_b |=> link_enable && link_mode_select == 8'h02
            && frames_per_multiframe_m1 == 8'h1F && manual_sync_request_n
            && sync_source_sel == SLC_SYNC_SE && sample_format && scrambler_enable
            && !upper_lane_mapping)
        else $error("register reset values wrong");

    chk_enable_write: assert property (
        (reg_wr && reg_addr == `SLC_ADDR_LINK_EN) |=> link_enable == $past(reg_wdata[0]))
        else $error("link enable write not taken");

    chk_disable_effects: assert property (
        !link_enable |-> !link_rst_b && serializer_pd && !link_clk_en)
        else $error("disabled link not held down");

    chk_mfc_held: assert property (
        (!link_enable && sysref_rise) |=> multiframe_clock_counter == 16'h0000)
        else $error("multiframe counter moved while disabled");

    chk_mode_refused: assert property (
        (reg_wr && reg_addr == `SLC_ADDR_MODE && !mode_permit[reg_wdata])
            |=> $stable(link_mode_select))
        else $error("locked mode accepted");

    chk_mode_taken: assert property (
        (reg_wr && reg_addr == `SLC_ADDR_MODE && mode_permit[reg_wdata])
            |=> link_mode_select == $past(reg_wdata))
        else $error("permitted mode not stored");

    chk_k_bypass: assert property (
        !mode_is_64b66b |-> effective_k_m1 == {8'h00, frames_per_multiframe_m1})
        else $error("8b/10b K does not follow frames field");

    chk_scramble_64: assert property (
        mode_is_64b66b |-> scrambler_active)
        else $error("64b/66b mode not scrambling");

    chk_sync_write: assert property (
        (reg_wr && reg_addr == `SLC_ADDR_SYNC && !reg_wdata[0]) |=> sync_request)
        else $error("manual sync write did not request");

    chk_ctrl_write: assert property (
        (reg_wr && reg_addr == `SLC_ADDR_CTRL)
            |=> sample_format == $past(reg_wdata[1]) && scrambler_enable == $past(reg_wdata[0]))
        else $error("control write not stored");

    cov_link_disable: cover property (link_enable ##1 !link_enable);
    cov_mode_refused: cover property (reg_wr && reg_addr == `SLC_ADDR_MODE
        && !mode_permit[reg_wdata]);
    cov_sysref_align: cover property (link_enable && sysref_rise
        && multiframe_clock_counter != 16'h0000);
    cov_mfc_wrap: cover property (frame_tick && multiframe_clock_counter == effective_k_m1);
endmodule

// ### logic/slc_params.svh
`ifndef SLC_PARAMS_SVH
`define SLC_PARAMS_SVH

// Register port geometry
`define SLC_ADDR_W 15
`define SLC_DATA_W 8

// Register offsets
`define SLC_ADDR_LINK_EN 15'h0200
`define SLC_ADDR_MODE 15'h0201
`define SLC_ADDR_KM1 15'h0202
`define SLC_ADDR_SYNC 15'h0203
`define SLC_ADDR_CTRL 15'h0204

// Field positions inside the control register
`define SLC_CTRL_SCR_BIT 0
`define SLC_CTRL_FMT_BIT 1
`define SLC_CTRL_SEL_LSB 2
`define SLC_CTRL_SEL_MSB 3
`define SLC_CTRL_LANE_BIT 4

// Reset values
`define SLC_RST_LINK_EN 1'h1
`define SLC_RST_MODE 8'h02
`define SLC_RST_KM1 8'h1F
`define SLC_RST_SYNC_N 1'h1
`define SLC_RST_CTRL 8'h03

// Multiplier turning E into frames before dividing by F
`define SLC_K_SCALE 16'h0100

`endif

// ### logic/slc_pkg.sv
package slc_pkg;
    `include "slc_params.svh"

    typedef logic [`SLC_ADDR_W-1:0] slc_addr_t;
    typedef logic [`SLC_DATA_W-1:0] slc_data_t;

    // Source of the link resynchronization request
    typedef enum logic [1:0] {
        SLC_SYNC_SE = 2'h0,
        SLC_SYNC_TS = 2'h1,
        SLC_SYNC_NONE = 2'h2
    } slc_sync_sel_t;
endpackage

// ### logic/slc_sync_req.sv
`timescale 1ns/1ns
module slc_sync_req (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic single_ended_sync_pin_n,
    input wire logic timestamp_pin_n,
    input wire logic sysref_pin,
    input wire logic manual_sync_request_n,
    input wire slc_pkg::slc_sync_sel_t sync_source_sel,
    output logic sync_request,
    output logic sysref_sync
);
    import slc_pkg::*;

    logic [2:0] meta;
    logic [2:0] stable;

    // Two-stage synchronisers; reset to idle so no false reference edge follows reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            meta <= 3'h3;
            stable <= 3'h3;
        end else begin
            meta <= {sysref_pin, timestamp_pin_n, single_ended_sync_pin_n};
            stable <= meta;
        end
    end

    assign sysref_sync = stable[2];

    // Manual bit always requests; a pin only when selected
    always_comb begin
        sync_request = !manual_sync_request_n;
        unique case (sync_source_sel)
            SLC_SYNC_SE: sync_request = sync_request | !stable[0];
            SLC_SYNC_TS: sync_request = sync_request | !stable[1];
            default: sync_request = sync_request;
        endcase
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_manual_sync_wins: assert property (
        !manual_sync_request_n |-> sync_request)
        else $error("manual sync request not raised");

    chk_no_pin_source: assert property (
        (sync_source_sel == SLC_SYNC_NONE && manual_sync_request_n) |-> !sync_request)
        else $error("pin leaked into request with no pin selected");

    chk_se_pin_path: assert property (
        (sync_source_sel == SLC_SYNC_SE && !single_ended_sync_pin_n)[*3] |-> sync_request)
        else $error("low sync pin did not request after two flops");

    cov_pin_request: cover property (
        sync_source_sel == SLC_SYNC_TS && manual_sync_request_n && sync_request);
endmodule

// ### verif/slc_rx_model.sv
`timescale 1ns/1ns
// Far-side stand-in: sync pins, reference pulse, frame ticks and mode table
module slc_rx_model (
    input wire logic [7:0] link_mode_select,
    input wire logic tick_en,
    input wire logic sysref_req,
    input wire logic [1:0] pin_low,
    output logic single_ended_sync_pin_n,
    output logic timestamp_pin_n,
    output logic sysref_pin,
    output logic frame_tick,
    output logic mode_is_64b66b,
    output logic [7:0] mode_e,
    output logic [7:0] mode_f
);
    // Pins idle high, a low level asks for resync
    assign single_ended_sync_pin_n = !pin_low[0];
    assign timestamp_pin_n = !pin_low[1];
    assign sysref_pin = sysref_req;
    assign frame_tick = tick_en;
    // Mode table: bit 4 picks 64b/66b, E=2 and F=8 give K=64
    assign mode_is_64b66b = link_mode_select[4];
    assign mode_e = 8'h02;
    assign mode_f = 8'h08;
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ns
`include "slc_params.svh"
module tb_top;
    import slc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    slc_addr_t reg_addr = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    slc_data_t reg_wdata = '0;
    slc_data_t reg_rdata;
    logic [255:0] mode_permit = ~(256'h1 << 255);
    logic tick_en = 1'b0;
    logic sysref_req = 1'b0;
    logic [1:0] pin_low = 2'h0;
    logic single_ended_sync_pin_n, timestamp_pin_n, sysref_pin, frame_tick, mode_is_64b66b;
    logic link_enable, link_rst_b, serializer_pd, link_clk_en, scrambler_active, sync_request;
    logic manual_sync_request_n, sample_format, scrambler_enable, upper_lane_mapping;
    logic [7:0] link_mode_select, frames_per_multiframe_m1, mode_e, mode_f;
    logic [15:0] effective_k_m1, multiframe_clock_counter;
    slc_sync_sel_t sync_source_sel;
    int mismatches = 0;
    int checks_done = 0;

    // Clock
    always #50 sys_clk = ~sys_clk;

    slc_link_regs u_dut (.sys_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .mode_permit, .mode_is_64b66b, .mode_e, .mode_f, .frame_tick, .single_ended_sync_pin_n,
        .timestamp_pin_n, .sysref_pin, .link_enable, .link_rst_b, .serializer_pd, .link_clk_en,
        .link_mode_select, .frames_per_multiframe_m1, .effective_k_m1, .multiframe_clock_counter,
        .sync_request, .manual_sync_request_n, .sync_source_sel, .sample_format,
        .scrambler_enable, .scrambler_active, .upper_lane_mapping);

    slc_rx_model u_rx (.link_mode_select, .tick_en, .sysref_req, .pin_low,
        .single_ended_sync_pin_n, .timestamp_pin_n, .sysref_pin, .frame_tick,
        .mode_is_64b66b, .mode_e, .mode_f);

    // Value compare
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Register write, strobe held across one rising edge
    task automatic wr(input slc_addr_t a, input slc_data_t d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask

    // Register read and compare
    task automatic rd(input slc_addr_t a, input slc_data_t exp, input string what);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        cyc(1);
        chk(what, 16'(exp), 16'(reg_rdata));
    endtask

    // Bounded wait for the sync request level
    task automatic wait_sync(input logic exp);
        int i;
        for (i = 0; i < 6 && sync_request !== exp; i++) cyc(1);
        chk("sync_request", 16'(exp), 16'(sync_request));
        if (sync_request !== exp) summarize();
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic t_reset();
        rd(`SLC_ADDR_LINK_EN, 8'(`SLC_RST_LINK_EN), "enable reg");
        rd(`SLC_ADDR_MODE, `SLC_RST_MODE, "mode reg");
        rd(`SLC_ADDR_KM1, `SLC_RST_KM1, "km1 reg");
        rd(`SLC_ADDR_SYNC, 8'(`SLC_RST_SYNC_N), "sync reg");
        rd(`SLC_ADDR_CTRL, `SLC_RST_CTRL, "ctrl reg");
        rd(15'h0205, 8'h00, "unmapped");
        chk("link_rst_b", 16'h1, 16'(link_rst_b));
        chk("serializer_pd", 16'h0, 16'(serializer_pd));
        chk("scrambler_active", 16'h1, 16'(scrambler_active));
        chk("effective_k_m1", 16'h001F, effective_k_m1);
        chk("sync_request", 16'h0, 16'(sync_request));
        $display("test reset done");
    endtask

    task automatic t_disable_mode();
        wr(`SLC_ADDR_LINK_EN, 8'h00);
        chk("link_enable", 16'h0, 16'(link_enable));
        chk("link_rst_b", 16'h0, 16'(link_rst_b));
        chk("serializer_pd", 16'h1, 16'(serializer_pd));
        chk("link_clk_en", 16'h0, 16'(link_clk_en));
        tick_en = 1'b1;
        sysref_req = 1'b1;
        cyc(6);
        tick_en = 1'b0;
        sysref_req = 1'b0;
        chk("counter idle", 16'h0, multiframe_clock_counter);
        wr(`SLC_ADDR_KM1, 8'h07);
        chk("frames_per_multiframe_m1", 16'h0007, 16'(frames_per_multiframe_m1));
        wr(`SLC_ADDR_MODE, 8'h11);
        rd(`SLC_ADDR_MODE, 8'h11, "mode reg");
        chk("link_mode_select", 16'h0011, 16'(link_mode_select));
        chk("effective_k_m1", 16'h003F, effective_k_m1);
        wr(`SLC_ADDR_CTRL, 8'h02);
        chk("scrambler_enable", 16'h0, 16'(scrambler_enable));
        chk("scrambler_active", 16'h1, 16'(scrambler_active));
        wr(`SLC_ADDR_MODE, 8'hFF);
        rd(`SLC_ADDR_MODE, 8'h11, "locked mode");
        wr(`SLC_ADDR_MODE, 8'h02);
        chk("scrambler_active", 16'h0, 16'(scrambler_active));
        chk("effective_k_m1", 16'h0007, effective_k_m1);
        chk("sample_format", 16'h1, 16'(sample_format));
        wr(`SLC_ADDR_CTRL, 8'h10);
        rd(`SLC_ADDR_CTRL, 8'h10, "ctrl reg");
        chk("upper_lane_mapping", 16'h1, 16'(upper_lane_mapping));
        chk("sample_format", 16'h0, 16'(sample_format));
        $display("test disable_mode done");
    endtask

    task automatic t_count();
        wr(`SLC_ADDR_LINK_EN, 8'h01);
        chk("link_clk_en", 16'h1, 16'(link_clk_en));
        tick_en = 1'b1;
        cyc(10);
        tick_en = 1'b0;
        chk("counter wrap", 16'h0002, multiframe_clock_counter);
        sysref_req = 1'b1;
        cyc(1);
        sysref_req = 1'b0;
        cyc(5);
        chk("counter realign", 16'h0, multiframe_clock_counter);
        $display("test count done");
    endtask

    task automatic t_sync();
        wr(`SLC_ADDR_LINK_EN, 8'h00);
        pin_low = 2'h1;
        wait_sync(1'b1);
        wr(`SLC_ADDR_CTRL, 8'h08);
        wait_sync(1'b0);
        wr(`SLC_ADDR_SYNC, 8'h00);
        wait_sync(1'b1);
        chk("manual_sync_request_n", 16'h0, 16'(manual_sync_request_n));
        wr(`SLC_ADDR_SYNC, 8'h01);
        wait_sync(1'b0);
        wr(`SLC_ADDR_CTRL, 8'h04);
        chk("sync_source_sel", 16'h1, 16'(sync_source_sel));
        wait_sync(1'b0);
        pin_low = 2'h2;
        wait_sync(1'b1);
        wr(`SLC_ADDR_CTRL, 8'h0C);
        wait_sync(1'b0);
        pin_low = 2'h0;
        wait_sync(1'b0);
        $display("test sync done");
    endtask

    // Mid-run reset brings enable, control, frames field and counter back to reset values; mode and manual sync unchecked
    task automatic t_rerun();
        rst_b = 1'b0;
        cyc(3);
        rst_b = 1'b1;
        cyc(1);
        chk("link_enable", 16'h1, 16'(link_enable));
        chk("sample_format", 16'h1, 16'(sample_format));
        chk("sync_source_sel", 16'h0, 16'(sync_source_sel));
        chk("counter reset", 16'h0, multiframe_clock_counter);
        rd(`SLC_ADDR_CTRL, `SLC_RST_CTRL, "ctrl reg");
        rd(`SLC_ADDR_KM1, `SLC_RST_KM1, "km1 reg");
        $display("test rerun done");
    endtask

    // Main sequence
    initial begin
        cyc(12);
        rst_b = 1'b1;
        cyc(1);
        t_reset();
        t_disable_mode();
        t_count();
        t_sync();
        t_rerun();
        summarize();
    end
endmodule
